// ==== nvtk_pkg.sv ====
/*
  nvtk_pkg: constants and carrier types of the timekeeping RAM block.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package nvtk_pkg;

  localparam int          ADDR_W          = 13;
  localparam int          DATA_W          = 8;
  localparam int          RAM_DEPTH       = 8192;

  localparam logic [12:0] CTRL_ADDR       = 13'h1FF8;
  localparam logic [12:0] SEC_ADDR        = 13'h1FF9;
  localparam logic [12:0] MIN_ADDR        = 13'h1FFA;
  localparam logic [12:0] HOUR_ADDR       = 13'h1FFB;
  localparam logic [12:0] WDAY_ADDR       = 13'h1FFC;
  localparam logic [12:0] MDAY_ADDR       = 13'h1FFD;
  localparam logic [12:0] MON_ADDR        = 13'h1FFE;
  localparam logic [12:0] YEAR_ADDR       = 13'h1FFF;

  localparam int          CTRL_WRITE_BIT  = 7;
  localparam int          CTRL_READ_BIT   = 6;
  localparam int          SEC_STOP_BIT    = 7;
  localparam int          WDAY_TEST_BIT   = 6;

  // used-bit masks: unused bits of each clock byte read back as zero
  localparam logic [7:0]  CTRL_MASK       = 8'hC0;
  localparam logic [7:0]  SEC_MASK        = 8'h7F;
  localparam logic [7:0]  MIN_MASK        = 8'h7F;
  localparam logic [7:0]  HOUR_MASK       = 8'h3F;
  localparam logic [7:0]  WDAY_MASK       = 8'h07;
  localparam logic [7:0]  MDAY_MASK       = 8'h3F;
  localparam logic [7:0]  MON_MASK        = 8'h1F;

  localparam logic [7:0]  SEC_RST         = 8'h00;
  localparam logic [7:0]  MIN_RST         = 8'h00;
  localparam logic [7:0]  HOUR_RST        = 8'h00;
  localparam logic [7:0]  WDAY_RST        = 8'h01;
  localparam logic [7:0]  MDAY_RST        = 8'h01;
  localparam logic [7:0]  MON_RST         = 8'h01;
  localparam logic [7:0]  YEAR_RST        = 8'h00;
  localparam logic [7:0]  CTRL_RST        = 8'h00;

  localparam int          CLK_HZ          = 40000000;
  localparam int          TEST_TICK_HZ    = 1024;
  // one toggle of the test bit per half period of 512 Hz
  localparam int          TICK_CYCLES     = CLK_HZ / TEST_TICK_HZ;
  localparam int          TICKS_PER_SEC   = TEST_TICK_HZ;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] mday;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } nvtk_time_t;

  localparam nvtk_time_t TIME_RST = '{YEAR_RST, MON_RST, MDAY_RST, WDAY_RST, HOUR_RST, MIN_RST, SEC_RST};

endpackage

// ==== nvtk_ram.sv ====
/*
  nvtk_ram: byte-wide storage for the ordinary RAM locations.
  Assumes one writer and one reader on the same clock; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module nvtk_ram #(
  parameter int AW    = 13,
  parameter int DW    = 8,
  parameter int DEPTH = 8192
) (
  input  wire logic          clk,      // system clock
  input  wire logic          wr_en,    // write strobe
  input  wire logic [AW-1:0] wr_addr,  // write address
  input  wire logic [DW-1:0] wr_data,  // write data
  input  wire logic [AW-1:0] rd_addr,  // read address
  output logic      [DW-1:0] rd_data   // registered read data
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ==== nvtk_counter.sv ====
/*
  nvtk_counter: BCD calendar counter chain with month length and leap years.
  Assumes a one-cycle second pulse and a load pulse from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvtk_counter (
  input  wire logic               clk,       // system clock
  input  wire logic               sys_rst,   // synchronous reset
  input  wire logic               sec_pulse, // advance one second
  input  wire logic               load,      // copy load_val into counters
  input  wire nvtk_pkg::nvtk_time_t load_val,  // value to load
  output nvtk_pkg::nvtk_time_t    count      // running counters
);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    // ten is 2 mod 4, so the year is a multiple of 4 when 2*tens + units is
    leap = (({yr[7:4], 1'b0} + {1'b0, yr[3:0]}) & 5'h03) == 5'h00;
    if (mon == 8'h02) begin
      month_last = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      month_last = 8'h30;
    end else begin
      month_last = 8'h31;
    end
  endfunction

  nvtk_pkg::nvtk_time_t nxt;

  // each field wraps at its BCD limit and carries upward
  always_comb begin
    nxt = count;
    if (count.sec == 8'h59) begin
      nxt.sec = 8'h00;
      if (count.min == 8'h59) begin
        nxt.min = 8'h00;
        if (count.hour == 8'h23) begin
          nxt.hour = 8'h00;
          nxt.wday = (count.wday == 8'h07) ? 8'h01 : bcd_inc(count.wday);
          if (count.mday >= month_last(count.mon, count.year)) begin
            nxt.mday = 8'h01;
            if (count.mon == 8'h12) begin
              nxt.mon  = 8'h01;
              nxt.year = (count.year == 8'h99) ? 8'h00 : bcd_inc(count.year);
            end else begin
              nxt.mon = bcd_inc(count.mon);
            end
          end else begin
            nxt.mday = bcd_inc(count.mday);
          end
        end else begin
          nxt.hour = bcd_inc(count.hour);
        end
      end else begin
        nxt.min = bcd_inc(count.min);
      end
    end else begin
      nxt.sec = bcd_inc(count.sec);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= nvtk_pkg::TIME_RST;
    end else if (load) begin
      count <= load_val;
    end else if (sec_pulse) begin
      count <= nxt;
    end
  end

endmodule
`default_nettype wire

// ==== nvtk_top.sv ====
/*
  nvtk_top: 8K x 8 byte RAM with a timekeeper in its top eight bytes.
  Assumes the host runs asynchronous SRAM cycles on pins that are synchronised
  here, with pulses long against 25 ns; supply state arrives as a level.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - control bit 6 set freezes the visible time bytes.
// - while frozen, visible bytes hold halt time; counters keep running.
// - clearing read-halt refreshes all visible bytes together within a second.
// - control bit 7 halts updates so host may load BCD time.
// - clearing write-halt loads visible values into counters and resumes.
// - seconds bit 7 stops the oscillator and all timekeeping.
// - weekday bit 6 makes seconds bit 0 toggle at 512Hz.
// - a held seconds read shows data line zero toggling at 512Hz.
// - clock bytes at 1FF8..1FFF with fixed BCD ranges.
// - data lines driven only when selected, output drive low, strobe high.
// - read mode follows address changes without a latch.
// - write active while strobe and select both asserted.
// - data captured at the end of the write.
// - read data driven until write strobe falls, then released.
// - below power-fail threshold the device forces itself deselected.
// - supply-fail reset output low during power fail.
// - lower addresses behave as ordinary byte RAM.
// - date rollover honours month lengths and leap years.
module nvtk_top (
  input  wire logic        clk,            // 40 MHz clock
  input  wire logic        sys_rst,        // synchronous reset
  input  wire logic [12:0] addr,           // address pins
  input  wire logic        ce_n,           // active-low select
  input  wire logic        select_high,    // active-high select
  input  wire logic        oe_n,           // output drive request, active low
  input  wire logic        we_n,           // write strobe, active low
  input  wire logic [7:0]  dq_in,          // data pins, input side
  output logic      [7:0]  dq_out,         // data pins, output side
  output logic             dq_oe,          // data pins drive enable
  input  wire logic        supply_low,     // supply below power_fail_threshold
  output logic             fail_rst_n_out, // open-drain reset, output level
  output logic             fail_rst_n_oe   // open-drain reset, drive enable
);

  // two-flop synchronisers on every pin input
  logic [12:0] addr_s1, addr_s2;
  logic [7:0]  dq_s1, dq_s2;
  logic [4:0]  ctl_s1, ctl_s2;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_s1 <= 13'h0000;
      addr_s2 <= 13'h0000;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
      // idle pins: deselected, strobes high, supply good, so no false fail pulse follows reset
      ctl_s1  <= 5'h1E;
      ctl_s2  <= 5'h1E;
    end else begin
      addr_s1 <= addr;
      addr_s2 <= addr_s1;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
      ctl_s1  <= {ce_n, ~select_high, oe_n, we_n, supply_low};
      ctl_s2  <= ctl_s1;
    end
  end

  // control pins unpacked after the second flop; nothing reads the first
  logic ce_ns, cel_s, oe_ns, we_ns, low_s;
  assign {ce_ns, cel_s, oe_ns, we_ns, low_s} = ctl_s2;

  // power fail forces the part deselected
  logic sel;
  assign sel = ~ce_ns & ~cel_s & ~low_s;

  logic wr_act, wr_act_d;
  assign wr_act = sel & ~we_ns;

  // the previous-cycle sample is the value present at the write's end
  logic [12:0] addr_d;
  logic [7:0]  dq_d;
  logic        wr_end;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_act_d <= 1'b0;
      addr_d   <= 13'h0000;
      dq_d     <= 8'h00;
    end else begin
      wr_act_d <= wr_act;
      addr_d   <= addr_s2;
      dq_d     <= dq_s2;
    end
  end

  // a write cut short by a sagging supply is dropped rather than stored
  assign wr_end = wr_act_d & ~wr_act & ~low_s;

  // one decode of the clock-byte window, shared by the write and read paths
  function automatic logic in_clock_area(input logic [12:0] a);
    in_clock_area = a[12:3] == nvtk_pkg::CTRL_ADDR[12:3];
  endfunction

  logic clk_area;
  assign clk_area = in_clock_area(addr_d);

  // supply-fail reset output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_rst_n_oe <= 1'b0;
    end else begin
      fail_rst_n_oe <= low_s;
    end
  end
  // only the enable moves: the pin is open drain and its level is fixed low
  assign fail_rst_n_out = 1'b0;

  // control byte
  // bits 5..0 are stored as zero so that they read back as zero
  logic [7:0] ctrl_reg;
  logic       rd_halt, wr_halt, wr_halt_d;
  assign rd_halt = ctrl_reg[nvtk_pkg::CTRL_READ_BIT];
  assign wr_halt = ctrl_reg[nvtk_pkg::CTRL_WRITE_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= nvtk_pkg::CTRL_RST;
    end else if (wr_end && addr_d == nvtk_pkg::CTRL_ADDR) begin
      ctrl_reg <= dq_d & nvtk_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_halt_d <= 1'b0;
    end else begin
      wr_halt_d <= wr_halt;
    end
  end

  // visible bytes and control bits
  nvtk_pkg::nvtk_time_t vis_reg, count;
  logic                 stop_reg, test_reg;

  // oscillator time base: 1024 Hz ticks, a second every 1024 ticks
  // whole cycles per tick make the second slightly short; that drift is accepted
  logic [15:0] div_cnt;
  logic [9:0]  tick_cnt;
  logic        tick, sec_pulse, test_phase;

  assign tick      = ~stop_reg && div_cnt == 16'(nvtk_pkg::TICK_CYCLES - 1);
  assign sec_pulse = tick && tick_cnt == 10'(nvtk_pkg::TICKS_PER_SEC - 1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt <= 16'h0000;
    end else if (stop_reg) begin
      // holding the phase lets a restarted oscillator finish the current second
      div_cnt <= div_cnt;
    end else if (tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 10'h000;
    end else if (tick) begin
      tick_cnt <= tick_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_phase <= 1'b0;
    end else if (tick && test_reg) begin
      // toggles only on real ticks, so a stopped oscillator freezes it too
      test_phase <= ~test_phase;
    end
  end

  // loading counters from visible bytes on write-halt release
  logic load;
  assign load = wr_halt_d & ~wr_halt;

  // counters pause under write-halt since its release reloads them anyway
  nvtk_counter u_counter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sec_pulse (sec_pulse & ~wr_halt),
    .load      (load),
    .load_val  (vis_reg),
    .count     (count)
  );

  // refresh of visible bytes: every cycle but the load cycle when no halt is set
  logic frozen;
  assign frozen = rd_halt | wr_halt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vis_reg <= nvtk_pkg::TIME_RST;
    end else if (wr_end && clk_area && wr_halt) begin
      case (addr_d[2:0])
        3'h1: vis_reg.sec  <= dq_d & nvtk_pkg::SEC_MASK;
        3'h2: vis_reg.min  <= dq_d & nvtk_pkg::MIN_MASK;
        3'h3: vis_reg.hour <= dq_d & nvtk_pkg::HOUR_MASK;
        3'h4: vis_reg.wday <= dq_d & nvtk_pkg::WDAY_MASK;
        3'h5: vis_reg.mday <= dq_d & nvtk_pkg::MDAY_MASK;
        3'h6: vis_reg.mon  <= dq_d & nvtk_pkg::MON_MASK;
        3'h7: vis_reg.year <= dq_d;
        default: vis_reg <= vis_reg;
      endcase
    end else if (!frozen && !load) begin
      // the load cycle is skipped: count still holds the old time then
      vis_reg <= count;
    end
  end

  // stop and test bits are written whether or not a halt is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_reg <= 1'b0;
    end else if (wr_end && addr_d == nvtk_pkg::SEC_ADDR) begin
      stop_reg <= dq_d[nvtk_pkg::SEC_STOP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_reg <= 1'b0;
    end else if (wr_end && addr_d == nvtk_pkg::WDAY_ADDR) begin
      test_reg <= dq_d[nvtk_pkg::WDAY_TEST_BIT];
    end
  end

  // plain RAM below the clock bytes
  logic [7:0] ram_q;
  logic       ram_wr;
  assign ram_wr = wr_end & ~clk_area;

  nvtk_ram #(
    .AW    (nvtk_pkg::ADDR_W),
    .DW    (nvtk_pkg::DATA_W),
    .DEPTH (nvtk_pkg::RAM_DEPTH)
  ) u_ram (
    .clk     (clk),
    .wr_en   (ram_wr),
    .wr_addr (addr_d),
    .wr_data (dq_d),
    .rd_addr (addr_s2),
    .rd_data (ram_q)
  );

  // read mux follows the address every cycle, no latching of read data
  logic [7:0] clk_q;
  logic       rd_clk_area;
  assign rd_clk_area = in_clock_area(addr_s2);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_q <= 8'h00;
    end else if (addr_s2 == nvtk_pkg::CTRL_ADDR) begin
      clk_q <= ctrl_reg;
    end else if (addr_s2 == nvtk_pkg::SEC_ADDR) begin
      clk_q <= {stop_reg, vis_reg.sec[6:1], test_reg ? test_phase : vis_reg.sec[0]};
    end else if (addr_s2 == nvtk_pkg::MIN_ADDR) begin
      clk_q <= vis_reg.min;
    end else if (addr_s2 == nvtk_pkg::HOUR_ADDR) begin
      clk_q <= vis_reg.hour;
    end else if (addr_s2 == nvtk_pkg::WDAY_ADDR) begin
      clk_q <= {1'b0, test_reg, vis_reg.wday[5:0]};
    end else if (addr_s2 == nvtk_pkg::MDAY_ADDR) begin
      clk_q <= vis_reg.mday;
    end else if (addr_s2 == nvtk_pkg::MON_ADDR) begin
      clk_q <= vis_reg.mon;
    end else begin
      clk_q <= vis_reg.year;
    end
  end

  // area select delayed one cycle to line up with the registered data
  logic rd_area_d;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_area_d <= 1'b0;
    end else begin
      rd_area_d <= rd_clk_area;
    end
  end

  assign dq_out = rd_area_d ? clk_q : ram_q;
  // the strobe falling with output drive low releases the bus at once
  // no turnaround gap is added here; the pad owns that timing
  assign dq_oe  = sel & ~oe_ns & we_ns;

endmodule
`default_nettype wire

// ==== nvtk_host.sv ====
/*
  nvtk_host: host bus master running asynchronous byte cycles on the pins.
  Assumes the 40 MHz bench clock; pins change by non-blocking assignment at edges.
*/
`timescale 1ns/1ps
`default_nettype none
module nvtk_host (
  input  wire logic        clk,         // bench clock
  output logic      [12:0] addr,        // address pins
  output logic             ce_n,        // active-low select
  output logic             select_high, // active-high select
  output logic             oe_n,        // output drive request
  output logic             we_n,        // write strobe
  output logic      [7:0]  dq_in,       // resolved data bus
  input  wire logic [7:0]  dq_out,      // device data
  input  wire logic        dq_oe        // device drive enable
);
  logic       drv = 1'b0;
  logic [7:0] drv_val = 8'h00;
  logic [7:0] last_val = 8'h00;

  // a floating bus keeps flipping, so stale data never passes for a write value
  assign dq_in = drv ? drv_val : (dq_oe ? dq_out : ~last_val);

  always_ff @(posedge clk) begin
    last_val <= dq_in;
  end

  initial begin
    addr = 13'h0000;
    ce_n = 1'b1;
    select_high = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
  end

  task automatic pins(input logic [12:0] a, input logic c, input logic o, input logic w, input logic dv,
                      input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    ce_n <= c;
    oe_n <= o;
    we_n <= w;
    drv <= dv;
    drv_val <= d;
  endtask

  task automatic idle(input int n);
    pins(addr, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
    repeat (n) @(posedge clk);
  endtask

  task automatic write(input logic [12:0] a, input logic [7:0] d);
    pins(a, 1'b0, 1'b1, 1'b0, 1'b1, d);
    repeat (4) @(posedge clk);
    pins(a, 1'b0, 1'b1, 1'b1, 1'b1, d);
    repeat (3) @(posedge clk);
    idle(3);
  endtask

  task automatic read(input logic [12:0] a, output logic [7:0] d, output logic oe);
    pins(a, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    repeat (6) @(posedge clk);
    d = dq_out;
    oe = dq_oe;
    idle(3);
  endtask
endmodule
`default_nettype wire

// ==== nvtk_top_assertions.sv ====
/*
  nvtk_top_assertions: port-level checks of the timekeeping RAM.
  Assumes binding to nvtk_top and pins held per the hand-over timing.
*/
`timescale 1ns/1ps
`default_nettype none
module nvtk_top_assertions (
  input wire logic        clk,            // clock
  input wire logic        sys_rst,        // synchronous reset
  input wire logic [12:0] addr,           // address pins
  input wire logic        ce_n,           // active-low select
  input wire logic        select_high,    // active-high select
  input wire logic        oe_n,           // output drive request
  input wire logic        we_n,           // write strobe
  input wire logic [7:0]  dq_out,         // read data
  input wire logic        dq_oe,          // data drive enable
  input wire logic        supply_low,     // supply below threshold
  input wire logic        fail_rst_n_out, // reset pin level
  input wire logic        fail_rst_n_oe   // reset pin drive
);
  logic rd_ok;
  // low supply deselects, so it is part of what makes a read answerable
  assign rd_ok = !ce_n && select_high && !oe_n && we_n && !supply_low;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_drive_needs_select: assert property (dq_oe |-> $past(rd_ok, 1) || $past(rd_ok, 2) || $past(rd_ok, 3))
    else $error("data driven without a valid read");
  a_drive_on_read: assert property (rd_ok [*4] |-> dq_oe)
    else $error("no drive during a settled read");
  a_release_on_strobe: assert property ((!we_n) [*4] |-> !dq_oe)
    else $error("data still driven under the write strobe");
  a_blocked_low_supply: assert property (supply_low [*4] |-> !dq_oe)
    else $error("data driven during power fail");
  a_fail_asserted: assert property (supply_low [*4] |-> fail_rst_n_oe)
    else $error("fail reset not pulled during power fail");
  a_fail_released: assert property ((!supply_low) [*4] |-> !fail_rst_n_oe)
    else $error("fail reset held with good supply");
  a_fail_low_level: assert property (fail_rst_n_oe |-> fail_rst_n_out == 1'b0)
    else $error("fail reset driven high");
  a_read_steady: assert property ((rd_ok && $stable(addr) && addr != nvtk_pkg::SEC_ADDR) [*6] |-> $stable(dq_out))
    else $error("read data moved with a steady address");
endmodule
bind nvtk_top nvtk_top_assertions u_chk (.clk, .sys_rst, .addr, .ce_n, .select_high, .oe_n, .we_n, .dq_out,
                                         .dq_oe, .supply_low, .fail_rst_n_out, .fail_rst_n_oe);
`default_nettype wire

// ==== testbench.sv ====
/*
  testbench: self-checking bench for nvtk_top driven through the host model.
  Assumes the checker is bound separately; one 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        supply_low = 1'b0;
  logic [12:0] addr;
  logic        ce_n, select_high, oe_n, we_n, dq_oe, fail_rst_n_out, fail_rst_n_oe;
  logic [7:0]  dq_in, dq_out;
  int          err_total = 0;
  int          checks = 0;

  always #12.5 clk = ~clk;

  nvtk_top u_dut (.clk, .sys_rst, .addr, .ce_n, .select_high, .oe_n, .we_n, .dq_in, .dq_out, .dq_oe,
                  .supply_low, .fail_rst_n_out, .fail_rst_n_oe);
  nvtk_host u_host (.clk, .addr, .ce_n, .select_high, .oe_n, .we_n, .dq_in, .dq_out, .dq_oe);

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    u_host.read(a, d, oe);
    cmp($sformatf("drive at %h", a), 32'h1, {31'h0, oe});
    cmp($sformatf("byte at %h", a), {24'h0, exp}, {24'h0, d});
  endtask

  task automatic t_reset_vals;
    logic [7:0] e [8] = '{nvtk_pkg::CTRL_RST, nvtk_pkg::SEC_RST, nvtk_pkg::MIN_RST, nvtk_pkg::HOUR_RST,
                          nvtk_pkg::WDAY_RST, nvtk_pkg::MDAY_RST, nvtk_pkg::MON_RST, nvtk_pkg::YEAR_RST};
    for (int i = 0; i < 8; i++) rd_chk(nvtk_pkg::CTRL_ADDR + 13'(i), e[i]);
  endtask

  task automatic t_ram;
    u_host.write(13'h0000, 8'hA5);
    u_host.write(13'h1FF7, 8'h5A);
    rd_chk(13'h0000, 8'hA5);
    rd_chk(13'h1FF7, 8'h5A);
    u_host.pins(13'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    repeat (6) @(posedge clk);
    cmp("drive with output off", 32'h0, {31'h0, dq_oe});
    u_host.idle(3);
    u_host.pins(13'h0000, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    u_host.select_high <= 1'b0;
    repeat (6) @(posedge clk);
    cmp("drive with high select low", 32'h0, {31'h0, dq_oe});
    u_host.idle(3);
    u_host.select_high <= 1'b1;
  endtask

  task automatic t_set_clock;
    logic [7:0] v [7] = '{8'h30, 8'h59, 8'h23, 8'h07, 8'h29, 8'h02, 8'h24};
    u_host.write(nvtk_pkg::CTRL_ADDR, 8'h80);
    for (int i = 0; i < 7; i++) u_host.write(nvtk_pkg::SEC_ADDR + 13'(i), v[i]);
    rd_chk(nvtk_pkg::CTRL_ADDR, 8'h80);
    u_host.write(nvtk_pkg::CTRL_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) rd_chk(nvtk_pkg::SEC_ADDR + 13'(i), v[i]);
    u_host.write(nvtk_pkg::MIN_ADDR, 8'h11);
    rd_chk(nvtk_pkg::MIN_ADDR, 8'h59);
  endtask

  task automatic t_halts;
    u_host.write(nvtk_pkg::CTRL_ADDR, 8'h40);
    rd_chk(nvtk_pkg::CTRL_ADDR, 8'h40);
    rd_chk(nvtk_pkg::HOUR_ADDR, 8'h23);
    u_host.write(nvtk_pkg::CTRL_ADDR, 8'h00);
    rd_chk(nvtk_pkg::HOUR_ADDR, 8'h23);
    u_host.write(nvtk_pkg::SEC_ADDR, 8'hB0);
    rd_chk(nvtk_pkg::SEC_ADDR, 8'hB0);
    u_host.write(nvtk_pkg::SEC_ADDR, 8'h30);
    rd_chk(nvtk_pkg::SEC_ADDR, 8'h30);
  endtask

  task automatic t_tick;
    logic b;
    int   n;
    u_host.write(nvtk_pkg::WDAY_ADDR, 8'h47);
    u_host.pins(nvtk_pkg::SEC_ADDR, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    repeat (6) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      b = dq_out[0];
      n = 0;
      while (dq_out[0] === b && n < 40000) begin
        @(posedge clk);
        n++;
      end
    end
    cmp("tick half period", nvtk_pkg::TICK_CYCLES, n);
    if (n >= 40000) results();
    cmp("seconds upper bits", 32'h30, {24'h0, dq_out[7:1], 1'b0});
    u_host.idle(3);
    u_host.write(nvtk_pkg::WDAY_ADDR, 8'h07);
  endtask

  task automatic t_oe_first;
    u_host.pins(13'h1FF7, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    repeat (6) @(posedge clk);
    cmp("drive before strobe", 32'h1, {31'h0, dq_oe});
    cmp("data before strobe", 32'h5A, {24'h0, dq_out});
    u_host.pins(13'h1FF7, 1'b0, 1'b0, 1'b0, 1'b1, 8'h5A);
    repeat (5) @(posedge clk);
    cmp("drive under strobe", 32'h0, {31'h0, dq_oe});
    u_host.pins(13'h1FF7, 1'b0, 1'b0, 1'b1, 1'b1, 8'h5A);
    repeat (3) @(posedge clk);
    u_host.idle(3);
    rd_chk(13'h1FF7, 8'h5A);
  endtask

  task automatic t_power;
    logic [7:0] d;
    logic       oe;
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("fail drive", 32'h1, {31'h0, fail_rst_n_oe});
    cmp("fail level", 32'h0, {31'h0, fail_rst_n_out});
    u_host.write(13'h0000, 8'h3C);
    u_host.read(13'h0000, d, oe);
    cmp("drive in fail", 32'h0, {31'h0, oe});
    supply_low <= 1'b0;
    repeat (4) @(posedge clk);
    cmp("fail drive", 32'h0, {31'h0, fail_rst_n_oe});
    rd_chk(13'h0000, 8'hA5);
  endtask

  task automatic results;
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset_vals();
    t_ram();
    t_set_clock();
    t_halts();
    t_tick();
    t_oe_first();
    t_power();
    results();
  end
endmodule
`default_nettype wire
